// File: sfc_pkg.sv
// Shared constants of the standard fast pulse counter.
// Assumes a 32-bit APB register window with word-aligned byte offsets.
package sfc_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] SFC_OFS_COUNT_MODE_SELECT = 8'h00;
   localparam logic [7:0] SFC_OFS_PRESET_TRIGGER = 8'h04;
   localparam logic [7:0] SFC_OFS_PRESET_LOW_WORD = 8'h08;
   localparam logic [7:0] SFC_OFS_PRESET_HIGH_WORD = 8'h0c;
   localparam logic [7:0] SFC_OFS_PULSES_PER_REV = 8'h10;
   localparam logic [7:0] SFC_OFS_LIVE_COUNT_LOW = 8'h14;
   localparam logic [7:0] SFC_OFS_LIVE_COUNT_HIGH = 8'h18;
   localparam logic [7:0] SFC_OFS_LATCHED_COUNT_LOW = 8'h1c;
   localparam logic [7:0] SFC_OFS_LATCHED_COUNT_HIGH = 8'h20;
   localparam logic [7:0] SFC_OFS_INPUT_ONE_FUNCTION = 8'h24;
   localparam logic [7:0] SFC_OFS_INPUT_TWO_FUNCTION = 8'h28;
   localparam logic [7:0] SFC_OFS_INPUT_THREE_FUNCTION = 8'h2c;

   // ------------------------------------------------------------
   // Reset values and legal limits
   // ------------------------------------------------------------
   localparam logic [2:0] SFC_RST_COUNT_MODE = 3'h0;
   localparam logic [15:0] SFC_RST_PRESET_WORD = 16'h0000;
   localparam logic [15:0] SFC_RST_PULSES_PER_REV = 16'h0400;
   localparam logic [15:0] SFC_MAX_COUNT_MODE = 16'h0004;
   localparam logic [15:0] SFC_MAX_TRIGGER = 16'h0001;
   localparam logic [15:0] SFC_MAX_IN3_FUNC = 16'h0002;

   // ------------------------------------------------------------
   // Count modes and input functions
   // ------------------------------------------------------------
   localparam logic [2:0] SFC_MODE_OFF = 3'h0;
   localparam logic [2:0] SFC_MODE_QUAD = 3'h1;
   localparam logic [2:0] SFC_MODE_PULSE_DIR = 3'h2;
   localparam logic [2:0] SFC_MODE_UP_DOWN = 3'h3;
   localparam logic [2:0] SFC_MODE_UP_ONLY = 3'h4;
   localparam logic [1:0] SFC_IN3_GENERAL = 2'h0;
   localparam logic [1:0] SFC_IN3_CAP_RISE = 2'h1;
   localparam logic [1:0] SFC_IN3_CAP_FALL = 2'h2;

endpackage : sfc_pkg

// File: sfc_evt_if.sv
// Carrier between the register core and the pin decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface sfc_evt_if;
   logic [2:0] mode;
   logic ch_a_en;
   logic ch_b_en;
   logic [1:0] cap_sel;
   logic count_up;
   logic count_down;
   logic capture;

   // Register core side
   modport core (output mode, output ch_a_en, output ch_b_en, output cap_sel,
                 input count_up, input count_down, input capture);
   // Pin decoder side
   modport dec (input mode, input ch_a_en, input ch_b_en, input cap_sel,
                output count_up, output count_down, output capture);
endinterface : sfc_evt_if

// File: sfc_edge_decode.sv
// Pin synchroniser and count-event decoder of the fast counter.
// Assumes asynchronous pins; events come out one cycle wide on clock.
`timescale 1ns/1ns
module sfc_edge_decode (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Raw pins
   input wire logic counter_input_a,
   input wire logic counter_input_b,
   input wire logic capture_input,
   // Events to the core
   sfc_evt_if.dec ev
);
   import sfc_pkg::*;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] prev;
   } sfc_dec_st_t;

   sfc_dec_st_t st_ff;
   sfc_dec_st_t nxt_st;
   logic a_cur, b_cur, a_old, b_old, c_cur, c_old;
   logic [1:0] quad;

   // ------------------------------------------------------------
   // Quadrature step: {up, down}; a skipped state counts nothing
   // ------------------------------------------------------------
   function automatic logic [1:0] sfc_quad_step(input logic [1:0] p, input logic [1:0] c);
      case ({p, c})
         4'b0010, 4'b1011, 4'b1101, 4'b0100: sfc_quad_step = 2'b10;
         4'b1000, 4'b1110, 4'b0111, 4'b0001: sfc_quad_step = 2'b01;
         default: sfc_quad_step = 2'b00;
      endcase
   endfunction : sfc_quad_step

   // Two-stage synchroniser, then a history stage for edges
   always_comb begin
      nxt_st.s1 = {capture_input, counter_input_b, counter_input_a};
      nxt_st.s2 = st_ff.s1;
      nxt_st.prev = st_ff.s2;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st; // RL14
      end
   end

   // Channel gating: both samples gated alike, so enabling makes no edge
   assign a_cur = ev.ch_a_en & st_ff.s2[0]; // RL6
   assign a_old = ev.ch_a_en & st_ff.prev[0]; // RL6
   assign b_cur = ev.ch_b_en & st_ff.s2[1]; // RL6
   assign b_old = ev.ch_b_en & st_ff.prev[1]; // RL6
   assign c_cur = st_ff.s2[2];
   assign c_old = st_ff.prev[2];
   assign quad = (ev.ch_a_en & ev.ch_b_en) ? sfc_quad_step({a_old, b_old}, {a_cur, b_cur}) : 2'b00; // RL6

   // Mode decode of count events
   always_comb begin
      ev.count_up = 1'b0;
      ev.count_down = 1'b0;
      case (ev.mode)
         SFC_MODE_QUAD: begin
            ev.count_up = quad[1]; // RL1
            ev.count_down = quad[0]; // RL1
         end
         SFC_MODE_PULSE_DIR: begin
            // Direction low counts up
            ev.count_up = a_cur & !a_old & !b_cur; // RL2
            ev.count_down = a_cur & !a_old & b_cur; // RL2
         end
         SFC_MODE_UP_DOWN: begin
            ev.count_up = a_cur & !a_old; // RL3
            ev.count_down = b_cur & !b_old; // RL3
         end
         SFC_MODE_UP_ONLY: begin
            ev.count_up = a_cur & !a_old; // RL4
         end
         default: begin
            ev.count_up = 1'b0; // RL5
         end
      endcase
   end

   // Capture on the selected transition of the third input
   assign ev.capture = (ev.cap_sel == SFC_IN3_CAP_RISE) ? (c_cur & !c_old) :
                       (ev.cap_sel == SFC_IN3_CAP_FALL) ? (!c_cur & c_old) : 1'b0; // RL7

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_up_only_nodown: assert property (@(posedge clock) disable iff (!reset_n) // RL4
      (ev.mode == SFC_MODE_UP_ONLY) |-> !ev.count_down)
      else $error("down event in up-only mode");
   a_updown_b_rise: assert property (@(posedge clock) disable iff (!reset_n) // RL3
      (ev.mode == SFC_MODE_UP_DOWN && ev.ch_b_en && st_ff.s2[1] && !st_ff.prev[1]) |-> ev.count_down)
      else $error("B rise did not count down");
   a_dir_from_b: assert property (@(posedge clock) disable iff (!reset_n) // RL2
      (ev.mode == SFC_MODE_PULSE_DIR && (ev.count_up || ev.count_down)) |-> (ev.count_down == b_cur))
      else $error("direction not taken from B");
   a_gate_chan_a: assert property (@(posedge clock) disable iff (!reset_n) // RL6
      !ev.ch_a_en |-> !ev.count_up)
      else $error("count from disabled channel A");
   a_quad_forward: assert property (@(posedge clock) disable iff (!reset_n) // RL1
      (ev.mode == SFC_MODE_QUAD && ev.ch_a_en && ev.ch_b_en && st_ff.prev[1:0] == 2'b00
       && st_ff.s2[1:0] == 2'b01) |-> ev.count_up)
      else $error("quadrature forward step missed");

endmodule : sfc_edge_decode

// File: sfc_counter.sv
// Standard fast pulse counter with its APB register file.
// Assumes one clock for bus and counter; pins may be asynchronous.
`timescale 1ns/1ns

// Contract
// [RL1] Mode 1 decodes A and B as quadrature, direction from phase.
// [RL2] Mode 2 counts A pulses, direction from level of B.
// [RL3] Mode 3: A pulses count up, B pulses count down.
// [RL4] Mode 4: A pulses count up, B ignored.
// [RL5] Mode register takes 0 to 4, resets to 0; 0 stops counting.
// [RL6] Only inputs one and two serve as channels, each by its function.
// [RL7] Input three captures count on chosen edge; capture readable separately.
// [RL8] Rising edge of the load bit presets the counter; levels do nothing.
// [RL9] Low preset word gives bits 15..0, range 0 to 65535, reset 0.
// [RL10] High preset word gives bits 31..16, reset 0.
// [RL11] Pulses per revolution takes 1 to 65535, resets to 1024.
// [RL12] Live count reads as separate low and high words.
// [RL13] Software must not preset while gearing follows this counter.
// [RL14] 32-bit two's-complement counter wraps silently; inputs sampled on clock.
module sfc_counter (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counter pins
   input wire logic counter_input_a,
   input wire logic counter_input_b,
   input wire logic capture_input,
   // Live state
   output logic [31:0] live_count,
   output logic [15:0] pulses_per_revolution
);
   import sfc_pkg::*;

   typedef struct packed {
      logic [2:0] mode;
      logic trig;
      logic trig_prev;
      logic [15:0] plo;
      logic [15:0] phi;
      logic [15:0] ppr;
      logic f1;
      logic f2;
      logic [1:0] f3;
      logic [31:0] count;
      logic [31:0] latch;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } sfc_top_st_t;

   sfc_top_st_t st_ff;
   sfc_top_st_t nxt_st;
   logic setup;
   logic wr;
   logic load_edge;
   logic mapped;
   logic [31:0] rdata;
   logic [15:0] wd;

   sfc_evt_if ev ();

   // ------------------------------------------------------------
   // Pin decoder
   // ------------------------------------------------------------
   sfc_edge_decode u_dec (
      .clock(clock),
      .reset_n(reset_n),
      .counter_input_a(counter_input_a),
      .counter_input_b(counter_input_b),
      .capture_input(capture_input),
      .ev(ev.dec)
   );

   // Configuration steering the decoder
   assign ev.mode = st_ff.mode; // RL5
   assign ev.ch_a_en = st_ff.f1; // RL6
   assign ev.ch_b_en = st_ff.f2; // RL6
   assign ev.cap_sel = st_ff.f3; // RL7

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Setup phase loads read data; access phase answers with no wait
   assign setup = psel & !penable;
   assign wr = psel & penable & st_ff.pready & pwrite;
   assign wd = pwdata[15:0];
   assign load_edge = st_ff.trig & !st_ff.trig_prev; // RL8

   // Read mux; narrow registers read zero above their width
   // No snapshot: a carry between the two word reads can tear them
   always_comb begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         SFC_OFS_COUNT_MODE_SELECT: rdata = {29'h0000_0000, st_ff.mode};
         SFC_OFS_PRESET_TRIGGER: rdata = {31'h0000_0000, st_ff.trig};
         SFC_OFS_PRESET_LOW_WORD: rdata = {16'h0000, st_ff.plo};
         SFC_OFS_PRESET_HIGH_WORD: rdata = {16'h0000, st_ff.phi};
         SFC_OFS_PULSES_PER_REV: rdata = {16'h0000, st_ff.ppr};
         SFC_OFS_LIVE_COUNT_LOW: rdata = {16'h0000, st_ff.count[15:0]}; // RL12
         SFC_OFS_LIVE_COUNT_HIGH: rdata = {16'h0000, st_ff.count[31:16]}; // RL12
         SFC_OFS_LATCHED_COUNT_LOW: rdata = {16'h0000, st_ff.latch[15:0]}; // RL7
         SFC_OFS_LATCHED_COUNT_HIGH: rdata = {16'h0000, st_ff.latch[31:16]}; // RL7
         SFC_OFS_INPUT_ONE_FUNCTION: rdata = {31'h0000_0000, st_ff.f1};
         SFC_OFS_INPUT_TWO_FUNCTION: rdata = {31'h0000_0000, st_ff.f2};
         SFC_OFS_INPUT_THREE_FUNCTION: rdata = {30'h0000_0000, st_ff.f3};
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pready = setup;
      nxt_st.pslverr = setup & !mapped;
      if (setup) begin
         nxt_st.prdata = rdata;
      end
      nxt_st.trig_prev = st_ff.trig;

      // Register writes; out-of-range mode, trigger, pulses-per-revolution and input three values are dropped, old value kept
      if (wr && mapped) begin
         case (paddr)
            SFC_OFS_COUNT_MODE_SELECT: begin
               if (wd <= SFC_MAX_COUNT_MODE) begin
                  nxt_st.mode = wd[2:0]; // RL5
               end
            end
            SFC_OFS_PRESET_TRIGGER: begin
               if (wd <= SFC_MAX_TRIGGER) begin
                  nxt_st.trig = wd[0]; // RL8
               end
            end
            SFC_OFS_PRESET_LOW_WORD: nxt_st.plo = wd; // RL9
            SFC_OFS_PRESET_HIGH_WORD: nxt_st.phi = wd; // RL10
            SFC_OFS_PULSES_PER_REV: begin
               if (wd != 16'h0000) begin
                  nxt_st.ppr = wd; // RL11
               end
            end
            SFC_OFS_INPUT_ONE_FUNCTION: nxt_st.f1 = wd[0]; // RL6
            SFC_OFS_INPUT_TWO_FUNCTION: nxt_st.f2 = wd[0]; // RL6
            SFC_OFS_INPUT_THREE_FUNCTION: begin
               if (wd <= SFC_MAX_IN3_FUNC) begin
                  nxt_st.f3 = wd[1:0]; // RL7
               end
            end
            default: begin
               nxt_st.pslverr = 1'b0;
            end
         endcase
      end

      // Capture takes the count before this cycle's step
      if (ev.capture) begin
         nxt_st.latch = st_ff.count; // RL7
      end

      // Nothing blocks a preset while gearing follows; software must avoid it
      // Preset wins over a pulse in the same cycle; that pulse is lost
      if (load_edge) begin
         nxt_st.count = {st_ff.phi, st_ff.plo}; // RL8
      end else if (ev.count_up && !ev.count_down) begin
         nxt_st.count = st_ff.count + 32'h0000_0001; // RL14
      end else if (ev.count_down && !ev.count_up) begin
         nxt_st.count = st_ff.count - 32'h0000_0001; // RL14
      end
   end

   // State register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= '0;
         st_ff.mode <= SFC_RST_COUNT_MODE; // RL5
         st_ff.plo <= SFC_RST_PRESET_WORD; // RL9
         st_ff.phi <= SFC_RST_PRESET_WORD; // RL10
         st_ff.ppr <= SFC_RST_PULSES_PER_REV; // RL11
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from state
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign live_count = st_ff.count;
   assign pulses_per_revolution = st_ff.ppr;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_preset_load: assert property (@(posedge clock) disable iff (!reset_n) // RL8
      load_edge
      |=> (st_ff.count == {$past(st_ff.phi), $past(st_ff.plo)}))
      else $error("preset not loaded on rising load bit");

   a_level_no_load: assert property (@(posedge clock) disable iff (!reset_n) // RL8
      (st_ff.trig && st_ff.trig_prev && !ev.count_up && !ev.count_down)
      |=> $stable(st_ff.count))
      else $error("count changed while load bit held");

   a_preset_low_bits: assert property (@(posedge clock) disable iff (!reset_n) // RL9
      load_edge
      |=> (st_ff.count[15:0] == $past(st_ff.plo)))
      else $error("low preset word not in bits 15..0");

   a_preset_high_bits: assert property (@(posedge clock) disable iff (!reset_n) // RL10
      load_edge
      |=> (st_ff.count[31:16] == $past(st_ff.phi)))
      else $error("high preset word not in bits 31..16");

   a_mode_legal: assert property (@(posedge clock) disable iff (!reset_n) // RL5
      (st_ff.mode <= SFC_MODE_UP_ONLY))
      else $error("count mode outside 0 to 4");

   a_mode_off_hold: assert property (@(posedge clock) disable iff (!reset_n) // RL5
      (st_ff.mode == SFC_MODE_OFF && !load_edge)
      |=> (st_ff.count == $past(st_ff.count)))
      else $error("counting while disabled");

   a_ppr_nonzero: assert property (@(posedge clock) disable iff (!reset_n) // RL11
      (st_ff.ppr != 16'h0000))
      else $error("pulses per revolution is zero");

   a_count_wraps: assert property (@(posedge clock) disable iff (!reset_n) // RL14
      (ev.count_up && !ev.count_down && !load_edge)
      |=> (st_ff.count == $past(st_ff.count) + 32'h0000_0001))
      else $error("up step wrong");

   a_capture_value: assert property (@(posedge clock) disable iff (!reset_n) // RL7
      ev.capture
      |=> (st_ff.latch == $past(st_ff.count)))
      else $error("capture did not hold the count");

   a_read_live_high: assert property (@(posedge clock) disable iff (!reset_n) // RL12
      (setup && paddr == SFC_OFS_LIVE_COUNT_HIGH)
      |=> (prdata == {16'h0000, $past(st_ff.count[31:16])}))
      else $error("live high word read wrong");

   // ------------------------------------------------------------
   // Register and step checks
   // ------------------------------------------------------------
   a_down_step: assert property (@(posedge clock) disable iff (!reset_n) // RL14
      (ev.count_down && !ev.count_up && !load_edge)
      |=> (st_ff.count == $past(st_ff.count) - 32'h0000_0001))
      else $error("down step wrong");

   a_latch_holds: assert property (@(posedge clock) disable iff (!reset_n) // RL7
      !ev.capture
      |=> $stable(st_ff.latch))
      else $error("latch moved without capture");

   a_chan_b_gate: assert property (@(posedge clock) disable iff (!reset_n) // RL6
      (!ev.ch_b_en && ev.mode == SFC_MODE_UP_DOWN)
      |-> !ev.count_down)
      else $error("count from disabled channel B");

   a_mode_refused: assert property (@(posedge clock) disable iff (!reset_n) // RL5
      (wr && paddr == SFC_OFS_COUNT_MODE_SELECT && wd > SFC_MAX_COUNT_MODE)
      |=> $stable(st_ff.mode))
      else $error("illegal mode taken");

   a_mode_taken: assert property (@(posedge clock) disable iff (!reset_n) // RL5
      (wr && paddr == SFC_OFS_COUNT_MODE_SELECT && wd <= SFC_MAX_COUNT_MODE)
      |=> (st_ff.mode == $past(wd[2:0])))
      else $error("legal mode not taken");

   a_ppr_zero_kept: assert property (@(posedge clock) disable iff (!reset_n) // RL11
      (wr && paddr == SFC_OFS_PULSES_PER_REV && wd == 16'h0000)
      |=> $stable(st_ff.ppr))
      else $error("zero pulses per revolution taken");

   a_ppr_taken: assert property (@(posedge clock) disable iff (!reset_n) // RL11
      (wr && paddr == SFC_OFS_PULSES_PER_REV && wd != 16'h0000)
      |=> (st_ff.ppr == $past(wd)))
      else $error("pulses per revolution not taken");

   a_low_word_taken: assert property (@(posedge clock) disable iff (!reset_n) // RL9
      (wr && paddr == SFC_OFS_PRESET_LOW_WORD)
      |=> (st_ff.plo == $past(wd)))
      else $error("low preset word not taken");

   a_high_word_taken: assert property (@(posedge clock) disable iff (!reset_n) // RL10
      (wr && paddr == SFC_OFS_PRESET_HIGH_WORD)
      |=> (st_ff.phi == $past(wd)))
      else $error("high preset word not taken");

   a_read_live_low: assert property (@(posedge clock) disable iff (!reset_n) // RL12
      (setup && paddr == SFC_OFS_LIVE_COUNT_LOW)
      |=> (prdata == {16'h0000, $past(st_ff.count[15:0])}))
      else $error("live low word read wrong");

   a_read_latch_low: assert property (@(posedge clock) disable iff (!reset_n) // RL7
      (setup && paddr == SFC_OFS_LATCHED_COUNT_LOW)
      |=> (prdata == {16'h0000, $past(st_ff.latch[15:0])}))
      else $error("latched low word read wrong");

endmodule : sfc_counter

// File: sfc_pulse_src.sv
// Behavioural pulse and quadrature source on the counter pins.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ns
module sfc_pulse_src (
   // Clock
   input wire logic clock,
   // Pins
   output logic pin_a,
   output logic pin_b,
   output logic pin_cap
);
   // ------------------------------------------------------------
   // Pin state
   // ------------------------------------------------------------
   int gap = 2;
   logic [1:0] q = 2'h0;
   initial {pin_a, pin_b, pin_cap} = 3'h0;

   // ------------------------------------------------------------
   // Pin tasks
   // ------------------------------------------------------------
   // Never faster than two cycles, else the sampler may miss a level
   task automatic hold();
      repeat ((gap < 2) ? 2 : gap) @(posedge clock);
   endtask : hold
   // One quarter step, A leads B when counting up
   task automatic quad(input logic up);
      q = up ? q + 2'h1 : q - 2'h1;
      pin_a <= (q == 2'h1) || (q == 2'h2);
      pin_b <= (q == 2'h2) || (q == 2'h3);
      hold();
   endtask : quad
   task automatic pulse(input logic on_b);
      if (on_b) pin_b <= 1'b1;
      else pin_a <= 1'b1;
      hold();
      if (on_b) pin_b <= 1'b0;
      else pin_a <= 1'b0;
      hold();
   endtask : pulse
   task automatic set_b(input logic v);
      pin_b <= v;
      hold();
   endtask : set_b
   task automatic set_cap(input logic v);
      pin_cap <= v;
      hold();
   endtask : set_cap
   task automatic idle();
      q = 2'h0;
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      hold();
   endtask : idle
endmodule : sfc_pulse_src

// File: standard_fast_pulse_counter_tb_top.sv
// Self-checking bench of the fast pulse counter and its APB registers.
// Assumes sfc_pkg, sfc_counter and sfc_pulse_src are compiled first.
`timescale 1ns/1ns
module standard_fast_pulse_counter_tb_top;
   import sfc_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clock = 1'b0;
   logic reset_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin_a;
   logic pin_b;
   logic pin_cap;
   logic [31:0] live_count;
   logic [15:0] ppr;
   logic [31:0] seed = 32'h5356;
   logic [31:0] cnt;
   logic [31:0] v;
   logic [31:0] rdv;
   logic err;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;

   always #4 clock = ~clock;

   sfc_counter uut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .counter_input_a(pin_a), .counter_input_b(pin_b), .capture_input(pin_cap),
      .live_count(live_count), .pulses_per_revolution(ppr));
   sfc_pulse_src src (.clock(clock), .pin_a(pin_a), .pin_b(pin_b), .pin_cap(pin_cap));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic summarize();
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   // Hang guard, far above the thousand or so cycles the run needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         summarize();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One APB transfer; idles a cycle after so strobes never toggle twice
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(name, exp, rdv);
   endtask : chk_rd

   // Pins are quiet here, so the two halves cannot tear
   task automatic chk_pair(input string name, input logic [7:0] a, input logic [31:0] exp);
      repeat (4) @(posedge clock);
      chk_rd({name, "_low"}, a, {16'h0, exp[15:0]});
      chk_rd({name, "_high"}, a + 8'h04, {16'h0, exp[31:16]});
      if (a == SFC_OFS_LIVE_COUNT_LOW) chk("live_port", exp, live_count);
   endtask : chk_pair

   // Expected count change of one event in a mode
   function automatic logic [31:0] delta(input logic [2:0] m, input logic [2:0] e);
      case (m)
         SFC_MODE_QUAD: return e[0] ? 32'hffffffff : 32'h1;
         SFC_MODE_PULSE_DIR: return e[1] ? 32'hffffffff : 32'h1;
         SFC_MODE_UP_DOWN: return e[0] ? 32'hffffffff : 32'h1;
         SFC_MODE_UP_ONLY: return e[0] ? 32'h0 : 32'h1;
         default: return 32'h0;
      endcase
   endfunction : delta

   task automatic drive(input logic [2:0] m, input logic [2:0] e);
      if (m == SFC_MODE_QUAD) begin
         src.quad(!e[0]);
      end else if (m == SFC_MODE_PULSE_DIR) begin
         src.set_b(e[1]);
         src.pulse(1'b0);
      end else begin
         src.pulse(e[0]);
      end
   endtask : drive

   // No gearing follows this counter here, so a jump is harmless
   task automatic preset(input logic [31:0] p);
      wr(SFC_OFS_PRESET_LOW_WORD, {16'h0, p[15:0]});
      wr(SFC_OFS_PRESET_HIGH_WORD, {16'h0, p[31:16]});
      wr(SFC_OFS_PRESET_TRIGGER, 32'h0);
      wr(SFC_OFS_PRESET_TRIGGER, 32'h1);
   endtask : preset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      // Idle bus, reset asserted from time zero
      {reset_n, psel, penable, pwrite, paddr, pwdata} <= '0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk_rd("mode", SFC_OFS_COUNT_MODE_SELECT, 32'h0);
      chk_rd("trigger", SFC_OFS_PRESET_TRIGGER, 32'h0);
      chk_rd("preset_low", SFC_OFS_PRESET_LOW_WORD, 32'h0);
      chk_rd("preset_high", SFC_OFS_PRESET_HIGH_WORD, 32'h0);
      chk_rd("ppr", SFC_OFS_PULSES_PER_REV, 32'h400);
      xfer(8'h30, 1'b0, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rdv);
      // Random setting kept, zero refused
      v = xs();
      v = {16'h0, v[15:0] | 16'h1};
      wr(SFC_OFS_PULSES_PER_REV, v);
      wr(SFC_OFS_PULSES_PER_REV, 32'h0);
      chk_rd("ppr", SFC_OFS_PULSES_PER_REV, v);
      chk("ppr_port", v, {16'h0, ppr});
      wr(SFC_OFS_INPUT_ONE_FUNCTION, 32'h1);
      wr(SFC_OFS_INPUT_TWO_FUNCTION, 32'h1);
      // Every mode with random events at random pacing
      cnt = 32'h0;
      for (int m = 0; m <= 4; m++) begin
         wr(SFC_OFS_COUNT_MODE_SELECT, 32'h0);
         src.idle();
         wr(SFC_OFS_COUNT_MODE_SELECT, m);
         for (int i = 0; i < 12; i++) begin
            v = xs();
            src.gap = 2 + int'(v[4:3]);
            drive(m[2:0], v[2:0]);
            cnt = cnt + delta(m[2:0], v[2:0]);
         end
         chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, cnt);
      end
      // Preset on the edge only, then wrap both ways
      v = xs();
      preset(v);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, v);
      wr(SFC_OFS_PRESET_LOW_WORD, ~v & 32'hffff);
      wr(SFC_OFS_PRESET_TRIGGER, 32'h1);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, v);
      preset(32'hffffffff);
      src.pulse(1'b0);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, 32'h0);
      wr(SFC_OFS_COUNT_MODE_SELECT, 32'h3);
      src.pulse(1'b1);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, 32'hffffffff);
      wr(SFC_OFS_INPUT_TWO_FUNCTION, 32'h0);
      src.pulse(1'b1);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, 32'hffffffff);
      wr(SFC_OFS_INPUT_ONE_FUNCTION, 32'h0);
      src.pulse(1'b0);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, 32'hffffffff);
      wr(SFC_OFS_INPUT_ONE_FUNCTION, 32'h1);
      // Capture on the chosen transition only
      wr(SFC_OFS_INPUT_THREE_FUNCTION, 32'h1);
      src.set_cap(1'b1);
      chk_pair("latch", SFC_OFS_LATCHED_COUNT_LOW, 32'hffffffff);
      src.pulse(1'b0);
      src.set_cap(1'b0);
      chk_pair("latch", SFC_OFS_LATCHED_COUNT_LOW, 32'hffffffff);
      wr(SFC_OFS_INPUT_THREE_FUNCTION, 32'h2);
      src.pulse(1'b0);
      src.set_cap(1'b1);
      src.set_cap(1'b0);
      chk_pair("latch", SFC_OFS_LATCHED_COUNT_LOW, 32'h1);
      chk_pair("live", SFC_OFS_LIVE_COUNT_LOW, 32'h1);
      wr(SFC_OFS_COUNT_MODE_SELECT, 32'h5);
      chk_rd("mode", SFC_OFS_COUNT_MODE_SELECT, 32'h3);
      summarize();
   end
endmodule : standard_fast_pulse_counter_tb_top
